// ==== ldm_char_rom.sv ====
// Purpose: shared constants and types for the multiplexed LED display controller,
//          plus the character to segment pattern lookup used on each character update.
// Assumes: segment bit 0 is segment a through bit 6 segment g, bit 7 the decimal point;
//          a 1 lights a segment.
// Notes: the character table is fixed in logic; changing the character set means
//        editing the case table below.
`default_nettype none

package ldm_pkg;
  // register byte offsets on the APB side
  localparam logic [7:0] LDM_OFS_DATA = 8'h00;
  localparam logic [7:0] LDM_OFS_STATUS = 8'h04;
  localparam logic [7:0] LDM_OFS_CTRL = 8'h08;
  localparam logic [7:0] LDM_OFS_LOAD = 8'h0C;
  localparam logic [7:0] LDM_OFS_MAP = 8'h20;
  localparam logic [7:0] LDM_MAP_SPAN = 8'h20;
  // status field positions
  localparam int LDM_ST_FULL = 0;
  localparam int LDM_ST_DIGIT = 1;
  localparam int LDM_ST_RUN = 4;
  // control field positions and reset value
  localparam int LDM_CT_REFRESH = 0;
  localparam int LDM_CT_INPUT = 1;
  localparam logic [1:0] LDM_CTRL_RESET = 2'h3;
  // display timing: 8-bit up-counter, one tick per 87 us, reload value 227
  localparam int LDM_CLK_MHZ = 50;
  localparam int LDM_TICK_US = 87;
  localparam int LDM_TICK_CYCLES = LDM_TICK_US * LDM_CLK_MHZ;
  localparam logic [7:0] LDM_TIMER_LOAD = 8'hE3;
  localparam int LDM_DIGITS = 8;
  localparam int LDM_DIGIT_W = 3;
  // segment patterns
  localparam logic [7:0] LDM_SEG_BLANK = 8'h00;
  localparam logic [7:0] LDM_SEG_DP = 8'h80;
  // character codes that are not plain numerics
  localparam logic [3:0] LDM_CHR_A = 4'hA;
  localparam logic [3:0] LDM_CHR_E = 4'hB;
  localparam logic [3:0] LDM_CHR_F = 4'hC;
  localparam logic [3:0] LDM_CHR_H = 4'hD;
  localparam logic [3:0] LDM_CHR_DP = 4'hE;
  localparam logic [3:0] LDM_CHR_BLANK = 4'hF;

  // display data word: digit select in the high nibble, character select in the low
  typedef struct packed {
    logic [3:0] digit;
    logic [3:0] char_code;
  } ldm_word_s;

  // refresh sequence, gray coded from wait to light; the return from light to wait flips two bits
  typedef enum logic [2:0] {
    LDM_WAIT = 3'h0,
    LDM_BLANK = 3'h1,
    LDM_SEGS = 3'h3,
    LDM_SELECT = 3'h2,
    LDM_LIGHT = 3'h6
  } ldm_refresh_e;
endpackage

module ldm_char_rom (
  // character in
  input wire logic [3:0] CHAR_CODE,
  // pattern out
  output logic [7:0] PATTERN,
  output logic IS_POINT
);
  import ldm_pkg::*;

  // numerics plus a few letters; the point code is merged by the caller
  always_comb begin
    IS_POINT = (CHAR_CODE == LDM_CHR_DP);
    unique case (CHAR_CODE)
      4'h0: PATTERN = 8'h3F;
      4'h1: PATTERN = 8'h06;
      4'h2: PATTERN = 8'h5B;
      4'h3: PATTERN = 8'h4F;
      4'h4: PATTERN = 8'h66;
      4'h5: PATTERN = 8'h6D;
      4'h6: PATTERN = 8'h7D;
      4'h7: PATTERN = 8'h07;
      4'h8: PATTERN = 8'h7F;
      4'h9: PATTERN = 8'h6F;
      LDM_CHR_A: PATTERN = 8'h77;
      LDM_CHR_E: PATTERN = 8'h79;
      LDM_CHR_F: PATTERN = 8'h71;
      LDM_CHR_H: PATTERN = 8'h76;
      LDM_CHR_DP: PATTERN = LDM_SEG_DP;
      LDM_CHR_BLANK: PATTERN = LDM_SEG_BLANK;
    endcase
  end
endmodule

`default_nettype wire

// ==== ldm_host.sv ====
// Purpose: host model posting display words over apb.
// Assumes: any number of wait states.
// Notes: poll is high during status polls so the bench skips them.
`default_nettype none
module ldm_host (
  // clock
  input wire logic CLK,
  // apb master
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldm_pkg::*;
  logic poll = 1'b0;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= data;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rdata = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWDATA <= ~data;
  endtask
  // overwriting a full buffer loses a word, so wait for it to drain first
  task automatic send(input logic [7:0] word);
    logic [31:0] st;
    logic err;
    poll <= 1'b1;
    st = 32'h1;
    for (int i = 0; i < 20 && st[LDM_ST_FULL] !== 1'b0; i++) begin
      xfer(1'b0, LDM_OFS_STATUS, 32'h0, st, err);
    end
    poll <= 1'b0;
    xfer(1'b1, LDM_OFS_DATA, {24'h0, word}, st, err);
  endtask
endmodule
`default_nettype wire

// ==== ldm_led_mux.sv ====
// Purpose: eight-digit multiplexed seven-segment display controller with an APB
//          register port, a host input buffer and a timed digit refresh.
// Assumes: single 50 MHz clock; an external 3-to-8 decoder drives the digit commons.
// Notes: APB answers with no wait states; read data is captured in the setup cycle.
`default_nettype none

module ldm_led_mux #(
  parameter int DIGITS = ldm_pkg::LDM_DIGITS,
  parameter int TICK_CYCLES = ldm_pkg::LDM_TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // display drive
  output logic [7:0] SEGMENT,
  output logic [ldm_pkg::LDM_DIGIT_W-1:0] DIGIT_NUMBER,
  output logic DECODER_ENABLE
);
  import ldm_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  localparam logic [LDM_DIGIT_W-1:0] DIGIT_LAST = LDM_DIGIT_W'(DIGITS - 1);

  // refuse sizes the three digit-number lines cannot serve
  if (DIGITS < 1 || DIGITS > (1 << LDM_DIGIT_W)) begin : g_bad_digits
    $error("DIGITS must be between 1 and 8");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // register and state declarations
  logic [7:0] display_map [DIGITS];
  ldm_word_s host_input_buffer;
  logic input_full_flag;
  logic [1:0] ctrl;
  logic [7:0] timer_load;
  logic [7:0] timer_count;
  logic [PRE_W-1:0] prescale;
  logic timer_run;
  logic [LDM_DIGIT_W-1:0] current_digit_counter;
  ldm_refresh_e state;
  ldm_refresh_e next_state;

  // apb decode
  logic setup_phase;
  logic access_phase;
  logic hit_data;
  logic hit_status;
  logic hit_ctrl;
  logic hit_load;
  logic hit_map;
  logic mapped;
  logic wr_data;
  logic [LDM_DIGIT_W-1:0] map_index;
  logic map_in_range;

  // input side
  logic consume;
  logic [7:0] lut_pattern;
  logic lut_point;
  logic digit_ok;

  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign hit_data = (PADDR == LDM_OFS_DATA);
  assign hit_status = (PADDR == LDM_OFS_STATUS);
  assign hit_ctrl = (PADDR == LDM_OFS_CTRL);
  assign hit_load = (PADDR == LDM_OFS_LOAD);
  assign map_index = PADDR[LDM_DIGIT_W+1:2];
  assign map_in_range = (32'(map_index) < DIGITS);
  assign hit_map = (PADDR >= LDM_OFS_MAP) && (PADDR < LDM_OFS_MAP + LDM_MAP_SPAN)
                   && (PADDR[1:0] == 2'h0) && map_in_range;
  assign mapped = hit_data || hit_status || hit_ctrl || hit_load || hit_map;
  assign wr_data = access_phase && PWRITE && hit_data;

  // zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase && !mapped;

  // read data is captured during setup so it comes from a flip-flop in access
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0;
    end else if (setup_phase && !PWRITE) begin
      PRDATA <= 32'h0;
      if (hit_data) begin
        PRDATA[7:0] <= host_input_buffer;
      end else if (hit_status) begin
        PRDATA[LDM_ST_FULL] <= input_full_flag;
        PRDATA[LDM_ST_DIGIT +: LDM_DIGIT_W] <= current_digit_counter;
        PRDATA[LDM_ST_RUN] <= timer_run;
      end else if (hit_ctrl) begin
        PRDATA[1:0] <= ctrl;
      end else if (hit_load) begin
        PRDATA[7:0] <= timer_load;
      end else if (hit_map) begin
        PRDATA[7:0] <= display_map[map_index];
      end
    end
  end

  // control: refresh and input enables, both on after reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= LDM_CTRL_RESET;
    end else if (access_phase && PWRITE && hit_ctrl) begin
      ctrl <= PWDATA[1:0];
    end
  end

  // timer reload value; 227 gives 29 ticks of 87 us per digit, 400 per second
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_load <= LDM_TIMER_LOAD;
    end else if (access_phase && PWRITE && hit_load) begin
      timer_load <= PWDATA[7:0];
    end
  end

  // input buffer: a host write stores the word; the host is trusted to poll first
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      host_input_buffer <= '0;
    end else if (wr_data) begin
      host_input_buffer <= PWDATA[7:0];
    end
  end

  // full flag: a write in the same cycle as the read-out wins, so no word is lost
  assign consume = input_full_flag && ctrl[LDM_CT_INPUT];
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      input_full_flag <= 1'b0;
    end else if (wr_data) begin
      input_full_flag <= 1'b1;
    end else if (consume) begin
      input_full_flag <= 1'b0;
    end
  end

  // character lookup for the buffered word
  ldm_char_rom u_rom (
    .CHAR_CODE(host_input_buffer.char_code),
    .PATTERN(lut_pattern),
    .IS_POINT(lut_point)
  );

  assign digit_ok = (32'(host_input_buffer.digit) < DIGITS);

  // display map: blank after reset, updated one word per consumed buffer whose digit is in range
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < DIGITS; i++) begin
        display_map[i] <= LDM_SEG_BLANK;
      end
    end else if (consume && digit_ok) begin
      if (lut_point) begin
        // point keeps the character already shown at that digit
        display_map[host_input_buffer.digit[LDM_DIGIT_W-1:0]] <=
          display_map[host_input_buffer.digit[LDM_DIGIT_W-1:0]] | LDM_SEG_DP;
      end else begin
        display_map[host_input_buffer.digit[LDM_DIGIT_W-1:0]] <= lut_pattern;
      end
    end
  end

  // interval timer: prescaler makes 87 us ticks, 8-bit up-counter stops on overflow
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prescale <= '0;
      timer_count <= LDM_TIMER_LOAD;
      timer_run <= 1'b1;
    end else if (state == LDM_LIGHT) begin
      prescale <= '0;
      timer_count <= timer_load;
      timer_run <= 1'b1;
    end else if (timer_run) begin
      if (prescale == PRE_LAST) begin
        prescale <= '0;
        timer_count <= timer_count + 8'h01;
        if (timer_count == 8'hFF) begin
          timer_run <= 1'b0;
        end
      end else begin
        prescale <= prescale + PRE_W'(1);
      end
    end
  end

  // refresh sequencer: one state per output step so the order is guaranteed
  always_comb begin
    next_state = state;
    unique case (state)
      LDM_WAIT: begin
        // a stopped timer means it overflowed; refresh disabled holds the wait
        if (!timer_run && ctrl[LDM_CT_REFRESH]) begin
          next_state = LDM_BLANK;
        end
      end
      LDM_BLANK: next_state = LDM_SEGS;
      LDM_SEGS: next_state = LDM_SELECT;
      LDM_SELECT: next_state = LDM_LIGHT;
      LDM_LIGHT: next_state = LDM_WAIT;
      default: next_state = LDM_WAIT;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= LDM_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // decoder enable: cleared in the blank step, set in the light step and held on through the wait while refresh is enabled, so no digit shows stale segments
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DECODER_ENABLE <= 1'b0;
    end else if (state == LDM_BLANK) begin
      DECODER_ENABLE <= 1'b0;
    end else if (state == LDM_LIGHT) begin
      DECODER_ENABLE <= 1'b1;
    end else if (state == LDM_WAIT && !ctrl[LDM_CT_REFRESH]) begin
      DECODER_ENABLE <= 1'b0; // refresh stopped: a held digit would overheat
    end
  end

  // segments: shared by all digits, changed only while the decoder is off
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SEGMENT <= LDM_SEG_BLANK;
    end else if (state == LDM_SEGS) begin
      SEGMENT <= display_map[current_digit_counter];
    end
  end

  // digit number to the external 3-to-8 decoder
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIGIT_NUMBER <= '0;
    end else if (state == LDM_SELECT) begin
      DIGIT_NUMBER <= current_digit_counter;
    end
  end

  // current digit advances once per refresh and wraps after the last digit
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      current_digit_counter <= '0;
    end else if (state == LDM_LIGHT) begin
      if (current_digit_counter == DIGIT_LAST) begin
        current_digit_counter <= '0;
      end else begin
        current_digit_counter <= current_digit_counter + LDM_DIGIT_W'(1);
      end
    end
  end
endmodule

`default_nettype wire

// ==== ldm_led_mux_chk.sv ====
// Purpose: port checks for the multiplexed display controller.
// Assumes: the reload value stays at its reset value.
// Notes: gap check would misfire if software changed the reload.
`default_nettype none
module ldm_led_mux_chk import ldm_pkg::*; #(
  parameter int TICK_CYCLES = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // display
  input wire logic [7:0] SEGMENT,
  input wire logic [ldm_pkg::LDM_DIGIT_W-1:0] DIGIT_NUMBER,
  input wire logic DECODER_ENABLE
);
  localparam int GAP = (256 - int'(LDM_TIMER_LOAD)) * TICK_CYCLES + 5;
  logic de_q;
  logic seen;
  logic [2:0] last_digit;
  logic [15:0] gap_cnt;
  wire logic rise = DECODER_ENABLE && !de_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // last lit digit and cycles since it lit; saturates so it never wraps
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      de_q <= 1'b0;
      seen <= 1'b0;
      last_digit <= 3'h0;
      gap_cnt <= 16'h0;
    end else begin
      de_q <= DECODER_ENABLE;
      if (rise) begin
        seen <= 1'b1;
        last_digit <= DIGIT_NUMBER;
        gap_cnt <= 16'h1;
      end else if (gap_cnt != 16'hFFFF) begin
        gap_cnt <= gap_cnt + 16'h1;
      end
    end
  end
  a_blank_first: assert property (!$stable(SEGMENT) |-> !DECODER_ENABLE)
    else $error("segments moved while lit");
  a_digit_hold: assert property (DECODER_ENABLE |-> $stable(DIGIT_NUMBER))
    else $error("digit number moved while lit");
  a_light_order: assert property ($rose(DECODER_ENABLE) |-> !$past(DECODER_ENABLE, 3))
    else $error("digit lit too soon after blanking");
  a_digit_step: assert property (rise && seen |-> DIGIT_NUMBER == last_digit + 3'h1)
    else $error("digit sequence broken");
  a_refresh_gap: assert property (rise && seen |-> gap_cnt == GAP)
    else $error("refresh interval wrong");
  a_ready_now: assert property (PSEL && !PENABLE ##1 PENABLE |-> PREADY)
    else $error("access not answered at once");
  a_err_unmapped: assert property (PSEL && PENABLE && PADDR == 8'h10 |-> PSLVERR)
    else $error("unmapped access not refused");
  a_data_ok: assert property (PSEL && PENABLE && PADDR == LDM_OFS_DATA |-> !PSLVERR)
    else $error("data access refused");
  c_lit: cover property (rise && seen);
  c_wrap: cover property (rise && DIGIT_NUMBER == 3'h0 && seen);
  c_err: cover property (PSEL && PENABLE && PSLVERR);
endmodule
bind ldm_led_mux ldm_led_mux_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SEGMENT(SEGMENT), .DIGIT_NUMBER(DIGIT_NUMBER),
  .DECODER_ENABLE(DECODER_ENABLE));
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the display controller.
// Assumes: plain seven segment codes for numerals and letters.
// Notes: TICK_CYCLES cut to 2, so one refresh every 63 clocks.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ldm_pkg::*;
  localparam int TICKS = 2;
  localparam logic [7:0] SEG_TAB [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
    8'h07, 8'h7F, 8'h6F, 8'h77, 8'h79, 8'h71, 8'h76, 8'h00, 8'h00};
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, decoder_enable;
  logic [7:0] paddr, segment;
  logic [31:0] pwdata, prdata, rd_val;
  logic [2:0] digit_number;
  logic [2:0] exp_digit = 3'h0;
  logic [3:0] dsel;
  logic [63:0] note;
  logic [63:0] notes [$];
  logic [7:0] exp_map [8];
  logic rd_err;
  logic watch = 1'b0;
  logic de_q = 1'b0;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  integer seed = 32'h079c;
  always #10 CLK = ~CLK;
  ldm_led_mux #(.TICK_CYCLES(TICKS)) uut (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SEGMENT(segment), .DIGIT_NUMBER(digit_number), .DECODER_ENABLE(decoder_enable));
  ldm_host host (
    .CLK(CLK), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // note the expected read first, so the watcher finds it at the access edge
  task automatic rd(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    notes.push_back({mask, exp});
    host.xfer(1'b0, addr, 32'h0, rd_val, rd_err);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    host.xfer(1'b1, addr, data, rd_val, rd_err);
  endtask
  // watcher: finished reads against notes, lit digits against the map model
  always @(posedge CLK) begin
    cycles++;
    if (psel && penable && pready && !pwrite && !host.poll) begin
      note = notes.pop_front();
      check("read data", prdata & note[63:32], note[31:0]);
    end
    de_q <= decoder_enable;
    if (decoder_enable && !de_q) begin
      if (watch) begin
        check("segments", {24'h0, segment}, {24'h0, exp_map[digit_number]});
        check("digit", {29'h0, digit_number}, {29'h0, exp_digit});
      end
      exp_digit <= digit_number + 3'h1;
    end
    if (cycles > 5000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 8; i++) exp_map[i] = LDM_SEG_BLANK;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(LDM_OFS_CTRL, 32'hFFFFFFFF, {30'h0, LDM_CTRL_RESET});
    rd(LDM_OFS_LOAD, 32'hFFFFFFFF, {24'h0, LDM_TIMER_LOAD});
    rd(LDM_OFS_STATUS, 32'h1, 32'h0);
    for (int i = 0; i < 8; i++) rd(LDM_OFS_MAP + 8'(4 * i), 32'hFF, 32'h0);
    $display("reset values done");
    // every code once; the point goes onto the digit just written
    for (int c = 0; c < 16; c++) begin
      if (c != 14) dsel = 4'($unsigned($random(seed)) % 8);
      exp_map[dsel[2:0]] = (c == 14) ? (exp_map[dsel[2:0]] | LDM_SEG_DP) : SEG_TAB[c];
      host.send({dsel, 4'(c)});
      rd(LDM_OFS_MAP + {3'h0, dsel[2:0], 2'h0}, 32'hFF, {24'h0, exp_map[dsel[2:0]]});
    end
    dsel = 4'h8 | 4'($unsigned($random(seed)) % 8);
    host.send({dsel, 4'h8});
    wr(LDM_OFS_MAP, 32'hFF);
    for (int i = 0; i < 8; i++) rd(LDM_OFS_MAP + 8'(4 * i), 32'hFF, {24'h0, exp_map[i]});
    $display("characters done");
    // input held off: the flag stays up until processing resumes
    wr(LDM_OFS_CTRL, 32'h1);
    wr(LDM_OFS_DATA, 32'h03);
    rd(LDM_OFS_STATUS, 32'h1, 32'h1);
    rd(LDM_OFS_MAP, 32'hFF, {24'h0, exp_map[0]});
    exp_map[0] = SEG_TAB[3];
    wr(LDM_OFS_CTRL, 32'h3);
    rd(LDM_OFS_STATUS, 32'h1, 32'h0);
    rd(LDM_OFS_MAP, 32'hFF, {24'h0, exp_map[0]});
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    check("unmapped error", {31'h0, rd_err}, 32'h1);
    $display("flag and refusal done");
    watch <= 1'b1;
    repeat (20 * (29 * TICKS + 5)) @(posedge CLK);
    $display("refresh done");
    print_verdict();
  end
endmodule
`default_nettype wire
